// file: include/dpm_pkg.sv
// Constants shared by the codepoint priority map and rate configuration block.
package dpm_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PRIO_W = 2;
   localparam int CODE_W = 6;
   localparam int NPORT  = 4;
   localparam int SRC_W  = 2;

   // Register offsets.
   localparam logic [ADDR_W-1:0] OFS_GCTL = 8'h87;
   localparam logic [ADDR_W-1:0] OFS_MAP0 = 8'h90;
   localparam logic [ADDR_W-1:0] OFS_MAP1 = 8'h91;
   localparam logic [ADDR_W-1:0] OFS_MAP2 = 8'h92;
   localparam logic [ADDR_W-1:0] OFS_MAP3 = 8'h93;
   localparam logic [ADDR_W-1:0] OFS_MAP4 = 8'h94;
   localparam logic [ADDR_W-1:0] OFS_MAP5 = 8'h95;
   localparam int MAP_REGS = 6;
   localparam int MAP_IDX_W = 3;

   // Reset values of the control and map registers, and field layout of the global control register.
   localparam logic [DATA_W-1:0] GCTL_RST   = 8'h10;
   localparam logic [DATA_W-1:0] MAP_RST    = 8'h00;
   localparam logic [DATA_W-1:0] GCTL_WMASK = 8'h3c;
   localparam int GCTL_PER_LSB = 4;
   localparam int GCTL_QEGR    = 3;
   localparam int GCTL_TAGSEL  = 2;

   // Codepoint position inside the TOS or traffic class byte.
   localparam int TOS_CODE_LSB = 2;

   // Whole table: 64 codepoints of two bits; the upper part lives outside.
   localparam int TABLE_W = 128;
   localparam int UPPER_W = TABLE_W - MAP_REGS * DATA_W;

   // Measurement period codes and times.
   localparam logic [1:0] PER_16  = 2'h0;
   localparam logic [1:0] PER_64  = 2'h1;
   localparam int CLK_MHZ    = 200;
   localparam int PER_16_MS  = 16;
   localparam int PER_64_MS  = 64;
   localparam int PER_256_MS = 256;
   localparam int CYC_16  = PER_16_MS * 1000 * CLK_MHZ;
   localparam int CYC_64  = PER_64_MS * 1000 * CLK_MHZ;
   localparam int CYC_256 = PER_256_MS * 1000 * CLK_MHZ;
   localparam int TMR_W = 26;
endpackage

// file: src/dpm_period_timer.sv
// Measurement period tick generator selected by a two-bit code.
`timescale 1ns/1ps
`default_nettype none
module dpm_period_timer #(
   parameter int W     = 26,
   parameter int CYC_A = 16,
   parameter int CYC_B = 64,
   parameter int CYC_C = 256
) (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic [1:0] i_sel,
   output logic            o_tick
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] load;
   logic [1:0]   sel_r;
   logic         chg;

   assign load = (i_sel == 2'h0) ? W'(CYC_A - 1) :
                 (i_sel == 2'h1) ? W'(CYC_B - 1) : W'(CYC_C - 1);
   assign chg  = (i_sel != sel_r);

   // A new period code restarts the interval rather than finishing the old one.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cnt_r  <= W'(CYC_B - 1);
         sel_r  <= 2'h1;
         o_tick <= 1'b0;
      end else begin
         sel_r  <= i_sel;
         o_tick <= !chg && (cnt_r == '0);
         if (chg || cnt_r == '0) begin
            cnt_r <= load;
         end else begin
            cnt_r <= cnt_r - W'(1);
         end
      end
   end
endmodule // dpm_period_timer
`default_nettype wire

// file: src/dpm_dscp_lookup.sv
// Codepoint to priority lookup for IP frames, one cycle of latency.
`timescale 1ns/1ps
`default_nettype none
module dpm_dscp_lookup
   import dpm_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire logic                 i_reset,
   input  wire logic [TABLE_W-1:0]   i_table,
   input  wire logic                 i_valid,
   input  wire logic                 i_is_ip,
   input  wire logic [DATA_W-1:0]    i_tos,
   output logic                      o_valid,
   output logic [PRIO_W-1:0]         o_prio,
   output logic [NPORT-1:0]          o_qsel
);
   logic [CODE_W-1:0] code;
   logic [PRIO_W-1:0] prio;

   assign code = i_tos[DATA_W-1:TOS_CODE_LSB];
   assign prio = i_table[{code, 1'b0} +: PRIO_W];

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_valid <= 1'b0;
         o_prio  <= '0;
         o_qsel  <= '0;
      end else begin
         o_valid <= i_valid && i_is_ip;
         o_prio  <= prio;
         o_qsel  <= NPORT'(1) << prio;
      end
   end
endmodule // dpm_dscp_lookup
`default_nettype wire

// file: src/dpm_config_top.sv
// Global rate and tag configuration plus the codepoint priority map.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dpm_config_top #(
   parameter int P_CYC_16  = dpm_pkg::CYC_16,
   parameter int P_CYC_64  = dpm_pkg::CYC_64,
   parameter int P_CYC_256 = dpm_pkg::CYC_256
) (
   input  wire logic                              i_clk,
   input  wire logic                              i_reset,
   input  wire logic [dpm_pkg::ADDR_W-1:0]        i_addr,
   input  wire logic [dpm_pkg::DATA_W-1:0]        i_wdata,
   input  wire logic                              i_wr,
   input  wire logic                              i_rd,
   output logic      [dpm_pkg::DATA_W-1:0]        o_rd_data,
   output logic      [1:0]                        o_rate_period,
   output logic                                   o_period_tick,
   output logic                                   o_egress_per_queue,
   output logic                                   o_tag_per_source,
   input  wire logic                              i_tag_valid,
   input  wire logic [dpm_pkg::SRC_W-1:0]         i_src_port,
   input  wire logic [dpm_pkg::NPORT-1:0]         i_port_ctrl0_ins,
   input  wire logic [dpm_pkg::NPORT*4-1:0]       i_src_ins_map,
   output logic                                   o_tag_valid,
   output logic      [dpm_pkg::NPORT-1:0]         o_pvid_insert,
   input  wire logic [dpm_pkg::UPPER_W-1:0]       i_map_upper,
   input  wire logic                              i_frame_valid,
   input  wire logic                              i_frame_is_ip,
   input  wire logic [dpm_pkg::DATA_W-1:0]        i_frame_tos,
   output logic                                   o_prio_valid,
   output logic      [dpm_pkg::PRIO_W-1:0]        o_prio,
   output logic      [dpm_pkg::NPORT-1:0]         o_queue_sel
);
   import dpm_pkg::*;

   // ****************************************************************
   // Register decode
   // ****************************************************************

   logic [DATA_W-1:0]                gctl_r;
   logic [MAP_REGS-1:0][DATA_W-1:0]  map_r;
   logic [DATA_W-1:0]                rd_nxt;
   logic [MAP_IDX_W-1:0]             map_idx;
   logic                             hit_gctl;
   logic                             hit_map;
   logic [MAP_REGS-1:0]              wr_map;
   logic                             wr_gctl;
   logic [TABLE_W-1:0]               table_flat;

   assign hit_gctl = (i_addr == OFS_GCTL);
   assign hit_map  = (i_addr >= OFS_MAP0) && (i_addr <= OFS_MAP5);
   assign map_idx  = MAP_IDX_W'(i_addr - OFS_MAP0);
   assign wr_gctl  = i_wr && hit_gctl;

   genvar gi;
   generate
      for (gi = 0; gi < MAP_REGS; gi++) begin : g_map
         assign wr_map[gi] = i_wr && (i_addr == ADDR_W'(OFS_MAP0 + gi));
      end
   endgenerate

   // Reserved bits of the control register read as zero.
   assign rd_nxt = hit_gctl ? (gctl_r & GCTL_WMASK) :
                   hit_map  ? map_r[map_idx] : '0;

   // ****************************************************************
   // Register storage
   // ****************************************************************

   // Reserved bits are not writable.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         gctl_r <= GCTL_RST;
      end else if (wr_gctl) begin
         gctl_r <= i_wdata & GCTL_WMASK;
      end
   end

   // Each map register holds four two-bit codepoint fields, lowest in 1:0.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         map_r <= {MAP_REGS{MAP_RST}};
      end else begin
         for (int k = 0; k < MAP_REGS; k++) begin
            if (wr_map[k]) begin
               map_r[k] <= i_wdata;
            end
         end
      end
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_rd_data <= '0;
      end else begin
         o_rd_data <= i_rd ? rd_nxt : '0;
      end
   end

   // ****************************************************************
   // Rate limiting and tag selection settings
   // ****************************************************************

   assign o_rate_period      = gctl_r[GCTL_PER_LSB +: 2];
   assign o_egress_per_queue = gctl_r[GCTL_QEGR];
   assign o_tag_per_source   = gctl_r[GCTL_TAGSEL];

   dpm_period_timer #(
      .W     (TMR_W),
      .CYC_A (P_CYC_16),
      .CYC_B (P_CYC_64),
      .CYC_C (P_CYC_256)
   ) u_timer (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_sel   (o_rate_period),
      .o_tick  (o_period_tick)
   );

   // ****************************************************************
   // Port tag insertion decision
   // ****************************************************************

   logic [NPORT-1:0] ins_nxt;

   generate
      for (gi = 0; gi < NPORT; gi++) begin : g_ins
         assign ins_nxt[gi] = o_tag_per_source ? i_src_ins_map[gi*4 + int'(i_src_port)]
                                               : i_port_ctrl0_ins[gi];
      end
   endgenerate

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_tag_valid   <= 1'b0;
         o_pvid_insert <= '0;
      end else begin
         o_tag_valid   <= i_tag_valid;
         o_pvid_insert <= ins_nxt;
      end
   end

   // ****************************************************************
   // Codepoint classification
   // ****************************************************************

   assign table_flat = {i_map_upper, map_r};

   dpm_dscp_lookup u_lookup (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_table (table_flat),
      .i_valid (i_frame_valid),
      .i_is_ip (i_frame_is_ip),
      .i_tos   (i_frame_tos),
      .o_valid (o_prio_valid),
      .o_prio  (o_prio),
      .o_qsel  (o_queue_sel)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   logic [TMR_W-1:0] gap_r;
   logic             gap_bad_r;
   logic [TMR_W-1:0] gap_exp;
   logic [1:0]       per_prev_r;

   assign gap_exp = (o_rate_period == PER_16) ? TMR_W'(P_CYC_16 - 1) :
                    (o_rate_period == PER_64) ? TMR_W'(P_CYC_64 - 1) : TMR_W'(P_CYC_256 - 1);

   // Cycles since the last tick; a period change spoils one interval.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         gap_r      <= '0;
         gap_bad_r  <= 1'b1;
         per_prev_r <= PER_64;
      end else begin
         per_prev_r <= o_rate_period;
         gap_r      <= o_period_tick ? '0 : gap_r + TMR_W'(1);
         if (o_rate_period != per_prev_r) begin
            gap_bad_r <= 1'b1;
         end else if (o_period_tick) begin
            gap_bad_r <= 1'b0;
         end
      end
   end

   sequence s_map0_write;
      i_wr && i_addr == OFS_MAP0;
   endsequence

   sequence s_map0_read;
      i_rd && i_addr == OFS_MAP0;
   endsequence

   period_gap_a: assert property (
      o_period_tick && !gap_bad_r && o_rate_period == per_prev_r |-> gap_r == gap_exp)
      else $error("period tick spacing wrong");

   period_rst_a: assert property (
      disable iff (1'b0) $past(i_reset) && !i_reset |-> o_rate_period == PER_64)
      else $error("period setting not 64 ms after reset");

   queue_mode_a: assert property (
      wr_gctl |=> o_egress_per_queue == $past(i_wdata[GCTL_QEGR]))
      else $error("egress limit mode not taken from write");

   tag_source_a: assert property (
      o_tag_per_source && !wr_gctl |=> o_pvid_insert[0] == $past(i_src_ins_map[int'(i_src_port)]))
      else $error("per source insertion choice wrong");

   tag_global_a: assert property (
      !o_tag_per_source && !wr_gctl |=> o_pvid_insert == $past(i_port_ctrl0_ins))
      else $error("port control insertion choice wrong");

   map_readback_a: assert property (
      s_map0_write ##1 s_map0_read |=> o_rd_data == $past(i_wdata, 2))
      else $error("map register read back differs");

   code_one_a: assert property (
      i_frame_valid && i_frame_is_ip && i_frame_tos[7:2] == 6'h01 && !i_wr
      |=> o_prio_valid && o_prio == map_r[0][3:2])
      else $error("codepoint 1 priority wrong");

   code_high_a: assert property (
      i_frame_valid && i_frame_is_ip && i_frame_tos[7:2] == 6'h17 && !i_wr
      |=> o_prio == map_r[5][7:6])
      else $error("codepoint 0x17 priority wrong");

   code_upper_a: assert property (
      i_frame_valid && i_frame_is_ip && i_frame_tos[7:2] == 6'h18
      |=> o_prio == $past(i_map_upper[1:0]))
      else $error("codepoint 0x18 priority wrong");

   non_ip_a: assert property (
      i_frame_valid && !i_frame_is_ip |=> !o_prio_valid)
      else $error("non IP frame classified");

   queue_sel_a: assert property (
      o_prio_valid |-> o_queue_sel == (NPORT'(1) << o_prio) && $onehot(o_queue_sel))
      else $error("queue select does not follow priority");

   rsv_zero_a: assert property (
      i_rd && hit_gctl |=> (o_rd_data & ~GCTL_WMASK) == '0)
      else $error("reserved control bits not zero");

   unmapped_a: assert property (
      i_rd && !hit_gctl && !hit_map |=> o_rd_data == '0)
      else $error("unmapped read not zero");

   sequence s_gctl_write;
      wr_gctl;
   endsequence

   period_wr_a: assert property (
      s_gctl_write |=> o_rate_period == $past(i_wdata[GCTL_PER_LSB +: 2]))
      else $error("period code not taken from write");

   tick_pulse_a: assert property (
      o_period_tick |=> !o_period_tick)
      else $error("period tick longer than one cycle");

   tick_restart_a: assert property (
      o_rate_period != per_prev_r |=> !o_period_tick)
      else $error("period change did not restart the interval");

   tag_sel_wr_a: assert property (
      s_gctl_write |=> o_tag_per_source == $past(i_wdata[GCTL_TAGSEL]))
      else $error("tag selection enable not taken from write");

   ctl_hold_a: assert property (
      !wr_gctl |=> $stable(gctl_r))
      else $error("control register changed without a write");

   tag_valid_a: assert property (
      i_tag_valid |=> o_tag_valid)
      else $error("tag decision not answered");

   tag_last_a: assert property (
      o_tag_per_source |=> o_pvid_insert[NPORT-1] == $past(i_src_ins_map[(NPORT-1)*4 + int'(i_src_port)]))
      else $error("per source insertion choice wrong on last port");

   map_hold_a: assert property (
      wr_map == '0 |=> $stable(map_r))
      else $error("map register changed without a write");

   rd_idle_a: assert property (
      !i_rd |=> o_rd_data == '0)
      else $error("read data present without a read");

   prio_valid_a: assert property (
      i_frame_valid && i_frame_is_ip |=> o_prio_valid)
      else $error("IP frame not classified");

   code_zero_a: assert property (
      i_frame_valid && i_frame_is_ip && i_frame_tos[7:2] == 6'h00 && !i_wr
      |=> o_prio == map_r[0][1:0])
      else $error("codepoint 0 priority wrong");

   code_four_a: assert property (
      i_frame_valid && i_frame_is_ip && i_frame_tos[7:2] == 6'h04 && !i_wr
      |=> o_prio == map_r[1][1:0])
      else $error("codepoint 4 priority wrong");

   code_0b_a: assert property (
      i_frame_valid && i_frame_is_ip && i_frame_tos[7:2] == 6'h0b && !i_wr
      |=> o_prio == map_r[2][7:6])
      else $error("codepoint 0x0b priority wrong");

   code_0c_a: assert property (
      i_frame_valid && i_frame_is_ip && i_frame_tos[7:2] == 6'h0c && !i_wr
      |=> o_prio == map_r[3][1:0])
      else $error("codepoint 0x0c priority wrong");

   code_13_a: assert property (
      i_frame_valid && i_frame_is_ip && i_frame_tos[7:2] == 6'h13 && !i_wr
      |=> o_prio == map_r[4][7:6])
      else $error("codepoint 0x13 priority wrong");

   upper_last_a: assert property (
      i_frame_valid && i_frame_is_ip && i_frame_tos[7:2] == 6'h3f
      |=> o_prio == $past(i_map_upper[UPPER_W-1 -: PRIO_W]))
      else $error("codepoint 0x3f priority wrong");

endmodule // dpm_config_top
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the codepoint priority map and rate configuration block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dpm_pkg::*;

   localparam int C16  = 20;
   localparam int C64  = 40;
   localparam int C256 = 80;

   logic                 i_clk;
   logic                 i_reset;
   logic [ADDR_W-1:0]    i_addr;
   logic [DATA_W-1:0]    i_wdata;
   logic                 i_wr;
   logic                 i_rd;
   logic [DATA_W-1:0]    o_rd_data;
   logic [1:0]           o_rate_period;
   logic                 o_period_tick;
   logic                 o_egress_per_queue;
   logic                 o_tag_per_source;
   logic                 i_tag_valid;
   logic [SRC_W-1:0]     i_src_port;
   logic [NPORT-1:0]     i_port_ctrl0_ins;
   logic [NPORT*4-1:0]   i_src_ins_map;
   logic                 o_tag_valid;
   logic [NPORT-1:0]     o_pvid_insert;
   logic [UPPER_W-1:0]   i_map_upper;
   logic                 i_frame_valid;
   logic                 i_frame_is_ip;
   logic [DATA_W-1:0]    i_frame_tos;
   logic                 o_prio_valid;
   logic [PRIO_W-1:0]    o_prio;
   logic [NPORT-1:0]     o_queue_sel;
   int                   error_cnt;
   int                   num_checks;
   logic [DATA_W-1:0]    mapv [MAP_REGS];
   logic [TABLE_W-1:0]   tbl;
   int                   n;

   dpm_config_top #(.P_CYC_16(C16), .P_CYC_64(C64), .P_CYC_256(C256)) dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rd_data(o_rd_data), .o_rate_period(o_rate_period), .o_period_tick(o_period_tick),
      .o_egress_per_queue(o_egress_per_queue), .o_tag_per_source(o_tag_per_source),
      .i_tag_valid(i_tag_valid), .i_src_port(i_src_port), .i_port_ctrl0_ins(i_port_ctrl0_ins),
      .i_src_ins_map(i_src_ins_map), .o_tag_valid(o_tag_valid), .o_pvid_insert(o_pvid_insert),
      .i_map_upper(i_map_upper), .i_frame_valid(i_frame_valid), .i_frame_is_ip(i_frame_is_ip),
      .i_frame_tos(i_frame_tos), .o_prio_valid(o_prio_valid), .o_prio(o_prio), .o_queue_sel(o_queue_sel)
   );

   always #2.5 i_clk = ~i_clk;

   task automatic results();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are looked at there.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1;
      chk("rd_data", o_rd_data, e);
   endtask

   // A write followed at once by a read of the same register.
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr    <= 1'b0;
      i_rd    <= 1'b1;
      @(posedge i_clk);
      i_rd    <= 1'b0;
      #1;
      chk("rd_data", o_rd_data, d);
   endtask

   task automatic frame(input logic ip, input logic [5:0] c);
      @(posedge i_clk);
      i_frame_valid <= 1'b1;
      i_frame_is_ip <= ip;
      i_frame_tos   <= {c, 2'h3};
      @(posedge i_clk);
      i_frame_valid <= 1'b0;
      #1;
      chk("prio_valid", o_prio_valid, ip);
      if (ip) begin
         chk("prio", o_prio, tbl[2*c +: 2]);
         chk("queue_sel", o_queue_sel, 4'h1 << tbl[2*c +: 2]);
      end
   endtask

   task automatic tag(input logic sel);
      for (int s = 0; s < 4; s++) begin
         @(posedge i_clk);
         i_tag_valid <= 1'b1;
         i_src_port  <= s[1:0];
         @(posedge i_clk);
         i_tag_valid <= 1'b0;
         #1;
         chk("tag_valid", o_tag_valid, 1'b1);
         for (int e = 0; e < NPORT; e++) begin
            chk("pvid_insert", o_pvid_insert[e], sel ? i_src_ins_map[e*4+s] : i_port_ctrl0_ins[e]);
         end
      end
   endtask

   task automatic tick_gap();
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (o_period_tick !== 1'b1 && n < 300);
      if (n >= 300) begin
         error_cnt++;
         $display("Error period_tick expected pulse seen none");
         results();
      end
   endtask

   initial begin
      i_clk = 1'b0;
      i_reset = 1'b1;
      i_addr = '0;
      i_wdata = '0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_tag_valid = 1'b0;
      i_src_port = '0;
      i_port_ctrl0_ins = 4'ha;
      i_src_ins_map = 16'h9c35;
      i_map_upper = {5{16'h1b6e}};
      i_frame_valid = 1'b0;
      i_frame_is_ip = 1'b0;
      i_frame_tos = '0;
      error_cnt = 0;
      num_checks = 0;
      mapv = '{8'he4, 8'h1b, 8'h93, 8'h6c, 8'hd8, 8'h27};
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b0;
      #1;
      chk("rate_period", o_rate_period, 2'h1);
      chk("egress_per_queue", o_egress_per_queue, 1'b0);
      chk("tag_per_source", o_tag_per_source, 1'b0);
      rd(OFS_GCTL, 8'h10);
      for (int i = 0; i < MAP_REGS; i++) begin
         rd(OFS_MAP0 + i[7:0], 8'h00);
         wr(OFS_MAP0 + i[7:0], mapv[i]);
      end
      for (int i = 0; i < MAP_REGS; i++) begin
         rd(OFS_MAP0 + i[7:0], mapv[i]);
      end
      wr(8'h96, 8'hff);
      rd(8'h96, 8'h00);
      tbl = {i_map_upper, mapv[5], mapv[4], mapv[3], mapv[2], mapv[1], mapv[0]};
      for (int c = 0; c < 64; c++) begin
         frame(1'b1, c[5:0]);
      end
      frame(1'b0, 6'h01);
      wr_rd(OFS_MAP0, 8'h5a);
      tag(1'b0);
      wr(OFS_GCTL, 8'hff);
      rd(OFS_GCTL, 8'h3c);
      chk("egress_per_queue", o_egress_per_queue, 1'b1);
      chk("tag_per_source", o_tag_per_source, 1'b1);
      tag(1'b1);
      for (int p = 0; p < 4; p++) begin
         wr(OFS_GCTL, 8'hc3 | (p[7:0] << 4));
         rd(OFS_GCTL, p[7:0] << 4);
         chk("rate_period", o_rate_period, p[1:0]);
         tick_gap();
         tick_gap();
         tick_gap();
         chk("tick_gap", n[15:0], p == 0 ? C16 : (p == 1 ? C64 : C256));
      end
      @(posedge i_clk);
      i_reset <= 1'b1;
      @(posedge i_clk);
      i_reset <= 1'b0;
      #1;
      chk("rate_period", o_rate_period, 2'h1);
      rd(OFS_GCTL, 8'h10);
      rd(OFS_MAP5, 8'h00);
      results();
   end
endmodule // testbench
`default_nettype wire
